// *** design/dsp_pkg.sv ***
package dsp_pkg;

  // ----------------------------------------------------------------
  // clocking and serial rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ_DEF = 250_000_000;
  localparam int unsigned BAUD_921K6 = 921_600;
  localparam int unsigned BAUD_460K6 = 460_600;
  localparam int unsigned BAUD_115K2 = 115_200;
  localparam int unsigned BAUD_57K6 = 57_600;
  localparam int unsigned BAUD_38K4 = 38_400;
  localparam int unsigned BAUD_19K2 = 19_200;
  localparam int unsigned BAUD_9K6 = 9_600;
  localparam int unsigned SPI_SCK_MAX_HZ = 20_000_000;

  // ----------------------------------------------------------------
  // uart configuration codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] BSEL_921K6 = 3'h0;
  localparam logic [2:0] BSEL_460K6 = 3'h1;
  localparam logic [2:0] BSEL_115K2 = 3'h2;
  localparam logic [2:0] BSEL_57K6 = 3'h3;
  localparam logic [2:0] BSEL_38K4 = 3'h4;
  localparam logic [2:0] BSEL_19K2 = 3'h5;
  localparam logic [2:0] BSEL_9K6 = 3'h6;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [2:0] BAUD_RST = BSEL_115K2;
  localparam logic [1:0] PAR_RST = PAR_EVEN;
  localparam logic STOP2_RST = 1'b0;
  localparam logic CTS_EN_RST = 1'b1;

  // ----------------------------------------------------------------
  // interrupt cause bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_W = 8;
  localparam int IRQ_RX_FULL = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_ERR = 2;
  localparam int IRQ_PARITY = 3;
  localparam int IRQ_NO_STOP = 4;
  localparam int IRQ_EXT_PIN = 5;
  localparam int IRQ_CORE = 6;
  localparam int CORE_IRQ_W = 2;
  localparam int NPINS = 3;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_NSS = 0;
  localparam int SY_SCK = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_PIN = 3;
  localparam int SY_W = 6;
  localparam logic [SY_W-1:0] SY_RST = 6'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_BOTH = 3'b001,
    DET_SPI = 3'b010,
    DET_UART = 3'b100
  } dsp_det_t;

  typedef enum logic [4:0] {
    U_IDLE = 5'b00001,
    U_START = 5'b00010,
    U_DATA = 5'b00100,
    U_PAR = 5'b01000,
    U_STOP = 5'b10000
  } dsp_ust_t;

  typedef struct packed {
    logic [2:0] baud;
    logic [1:0] parity;
    logic two_stop;
    logic cts_en;
  } dsp_ucfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic from_uart;
  } dsp_rx_t;

  typedef struct packed {
    logic [NPINS-1:0] is_input;
    logic [NPINS-1:0][IRQ_W-1:0] mask;
  } dsp_map_t;

endpackage

// *** design/dsp_sync.sv ***
`timescale 1ns/10ps
// two-stage synchroniser, one lane per bit
module dsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [2*W-1:0] st;
  logic [2*W-1:0] next_st;

  // first stage feeds only the second
  always_comb begin
    next_st = {st[W-1:0], d};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st[2*W-1:W];
endmodule

// *** design/dsp_port.sv ***
`timescale 1ns/10ps
// Summary of operation
// - SPI and UART both listen after reset; first valid transaction locks out the other.
// - shared clock pin weakly pulled low; UART drives it, SPI makes it input.
// - SPI slave only, clock polarity zero, phase zero.
// - write is address then data byte; read is address then returned byte.
// - MOSI sampled on rising SCK, MISO changed on falling SCK.
// - transfer starts with select low; MISO released while select high.
// - SPI shifting follows host SCK, up to 20 MHz.
// - SPI transaction ends when select rises; no length field.
// - short SPI transaction still ends the command; missing parameters undefined; here at least one full byte is needed.
// - no start delay when awake; select fall in sleep requests wake-up.
// - busy high during sleep, init and start-up until standby reached.
// - UART rates 921.6k to 9.6k, 8 bits, parity, 1 or 2 stops, flow control.
// - UART resets to 115.2k, one stop, even parity, CTS flow, LSB first.
// - UART command ends when the supplied byte count has arrived.
// - UART events: receive full, transmit empty, parity and stop errors.
// - select/CTS, clock/RTS, MOSI/RX and MISO/TX share pins.
// - three pins, each mappable to any interrupt or used as external input.
// - busy pin always output; its fall signals ready for next command.
// - interrupt cause readable; cleared only by explicit clear command.
// - SPI returns status when no data queued; UART only on request.
// - busy high during every transaction and processing, low when ready; a UART transaction raises it only after its first byte.
// - a parameterless command is one opcode byte on either interface.
module dsp_port #(
  parameter int unsigned CLK_HZ = dsp_pkg::CLK_HZ_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_nss_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sck_pull_low,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  output logic busy,
  input wire logic [dsp_pkg::NPINS-1:0] mp_pin_in,
  output logic [dsp_pkg::NPINS-1:0] mp_pin_out,
  output logic [dsp_pkg::NPINS-1:0] mp_pin_oe,
  input wire logic sleep_mode,
  input wire logic standby_reached,
  input wire logic core_busy,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  output logic tx_ready,
  output dsp_pkg::dsp_rx_t rx,
  input wire logic [7:0] cmd_len,
  output logic cmd_done,
  output logic wake_req,
  input wire dsp_pkg::dsp_ucfg_t ucfg_in,
  input wire logic ucfg_load,
  input wire dsp_pkg::dsp_map_t map_in,
  input wire logic map_load,
  input wire logic [dsp_pkg::IRQ_W-1:0] clr_mask,
  input wire logic clr_load,
  input wire logic [dsp_pkg::CORE_IRQ_W-1:0] core_irq,
  output logic [dsp_pkg::IRQ_W-1:0] irq_cause,
  output dsp_pkg::dsp_det_t det_mode
);
  import dsp_pkg::*;

  // ----------------------------------------------------------------
  // baud divisors, one bit time minus one
  // ----------------------------------------------------------------
  localparam logic [6:0][15:0] DIVS = {
    16'(CLK_HZ / BAUD_9K6 - 1), 16'(CLK_HZ / BAUD_19K2 - 1),
    16'(CLK_HZ / BAUD_38K4 - 1), 16'(CLK_HZ / BAUD_57K6 - 1),
    16'(CLK_HZ / BAUD_115K2 - 1), 16'(CLK_HZ / BAUD_460K6 - 1),
    16'(CLK_HZ / BAUD_921K6 - 1)};

  typedef struct packed {
    dsp_det_t det;
    logic [SY_W-1:0] prev;
    logic spi_act;
    logic [2:0] spi_bit;
    logic [7:0] spi_rx;
    logic [7:0] spi_tx;
    logic [7:0] spi_cnt;
    logic pend;
    logic [7:0] pend_d;
    dsp_ust_t urx;
    logic [15:0] urx_div;
    logic [2:0] urx_bit;
    logic [7:0] urx_sh;
    logic urx_perr;
    logic [7:0] ucnt;
    logic len_chk;
    dsp_ust_t utx;
    logic [15:0] utx_div;
    logic [2:0] utx_bit;
    logic [7:0] utx_sh;
    logic utx_stop2;
    dsp_ucfg_t cfg;
    logic [IRQ_W-1:0] cause;
    dsp_map_t map;
    logic txn;
    logic [1:0] hold;
    logic busy;
    logic sck_out;
    logic sck_oe;
    logic sck_pull;
    logic miso_out;
    logic miso_oe;
    dsp_rx_t rx;
    logic cmd_done;
    logic wake;
    logic [NPINS-1:0] pin_out;
  } dsp_state_t;

  dsp_state_t st;
  dsp_state_t next_st;
  logic [SY_W-1:0] sy;
  logic [IRQ_W-1:0] ev;
  logic [15:0] div;
  logic nss_fall;
  logic nss_rise;
  logic sck_rise;
  logic sck_fall;
  logic rx_fall;
  logic spi_on;
  logic uart_on;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dsp_sync #(.W(SY_W), .RST_VAL(SY_RST)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({mp_pin_in, mosi_in, sck_in, spi_nss_in}),
    .q(sy)
  );

  // edges from the synchronised copies
  assign nss_fall = st.prev[SY_NSS] && !sy[SY_NSS];
  assign nss_rise = !st.prev[SY_NSS] && sy[SY_NSS];
  assign sck_rise = !st.prev[SY_SCK] && sy[SY_SCK];
  assign sck_fall = st.prev[SY_SCK] && !sy[SY_SCK];
  assign rx_fall = st.prev[SY_MOSI] && !sy[SY_MOSI];
  assign spi_on = st.det != DET_UART;
  assign uart_on = st.det != DET_SPI;
  assign div = DIVS[(st.cfg.baud > BSEL_9K6) ? BSEL_9K6 : st.cfg.baud];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    ev = '0;
    next_st.prev = sy;
    next_st.rx.valid = 1'b0;
    next_st.cmd_done = 1'b0;
    next_st.wake = 1'b0;
    next_st.len_chk = 1'b0;
    if (st.hold != 2'h0) begin
      next_st.hold = st.hold - 2'h1;
    end

    // configuration strobes from the command decoder
    if (ucfg_load) begin
      next_st.cfg = ucfg_in;
    end
    if (map_load) begin
      next_st.map = map_in;
    end
    if (tx_load && !st.pend) begin
      next_st.pend = 1'b1;
      next_st.pend_d = tx_data;
    end

    // wake-up request on select fall while asleep
    if (nss_fall && sleep_mode) begin
      next_st.wake = 1'b1;
    end

    // spi slave, mode 0, msb first
    if (spi_on) begin
      if (nss_fall) begin
        next_st.spi_act = 1'b1;
        next_st.spi_bit = 3'h0;
        next_st.spi_cnt = 8'h00;
        next_st.txn = 1'b1;
        next_st.spi_tx = st.pend ? st.pend_d : status_byte;
        next_st.miso_out = st.pend ? st.pend_d[7] : status_byte[7];
        next_st.pend = next_st.pend && !st.pend; // a load in this cycle survives
      end else if (st.spi_act && nss_rise) begin
        next_st.spi_act = 1'b0;
        next_st.txn = 1'b0;
        next_st.hold = 2'h2;
        next_st.cmd_done = st.spi_cnt != 8'h00;
      end else if (st.spi_act && sck_rise) begin
        next_st.spi_rx = {st.spi_rx[6:0], sy[SY_MOSI]};
        next_st.spi_bit = st.spi_bit + 3'h1;
        if (st.spi_bit == 3'h7) begin
          next_st.rx = '{data: {st.spi_rx[6:0], sy[SY_MOSI]}, valid: 1'b1, from_uart: 1'b0};
          next_st.spi_cnt = st.spi_cnt + 8'h01;
          next_st.det = DET_SPI;
        end
      end else if (st.spi_act && sck_fall) begin
        if (st.spi_bit == 3'h0) begin
          next_st.spi_tx = st.pend ? st.pend_d : status_byte;
          next_st.miso_out = st.pend ? st.pend_d[7] : status_byte[7];
          next_st.pend = next_st.pend && !st.pend;
        end else begin
          next_st.spi_tx = {st.spi_tx[6:0], 1'b0};
          next_st.miso_out = st.spi_tx[6];
        end
      end
      next_st.miso_oe = next_st.spi_act;
    end

    // uart receiver, lsb first
    if (uart_on) begin
      unique case (st.urx)
        U_IDLE: begin
          if (rx_fall) begin
            next_st.urx = U_START;
            next_st.urx_div = {1'b0, div[15:1]};
          end
        end
        U_START: begin
          if (st.urx_div != 16'h0000) begin
            next_st.urx_div = st.urx_div - 16'h0001;
          end else if (!sy[SY_MOSI]) begin
            next_st.urx = U_DATA;
            next_st.urx_div = div;
            next_st.urx_bit = 3'h0;
            next_st.urx_perr = 1'b0;
          end else begin
            next_st.urx = U_IDLE;
          end
        end
        U_DATA: begin
          if (st.urx_div != 16'h0000) begin
            next_st.urx_div = st.urx_div - 16'h0001;
          end else begin
            next_st.urx_sh = {sy[SY_MOSI], st.urx_sh[7:1]};
            next_st.urx_bit = st.urx_bit + 3'h1;
            next_st.urx_div = div;
            if (st.urx_bit == 3'h7) begin
              next_st.urx = (st.cfg.parity == PAR_NONE) ? U_STOP : U_PAR;
            end
          end
        end
        U_PAR: begin
          if (st.urx_div != 16'h0000) begin
            next_st.urx_div = st.urx_div - 16'h0001;
          end else begin
            next_st.urx_perr = (^st.urx_sh ^ sy[SY_MOSI]) != (st.cfg.parity == PAR_ODD);
            next_st.urx_div = div;
            next_st.urx = U_STOP;
          end
        end
        U_STOP: begin
          if (st.urx_div != 16'h0000) begin
            next_st.urx_div = st.urx_div - 16'h0001;
          end else begin
            next_st.urx = U_IDLE;
            next_st.rx = '{data: st.urx_sh, valid: 1'b1, from_uart: 1'b1};
            next_st.ucnt = st.ucnt + 8'h01;
            next_st.len_chk = 1'b1;
            next_st.txn = 1'b1;
            ev[IRQ_RX_FULL] = 1'b1;
            ev[IRQ_PARITY] = st.urx_perr;
            ev[IRQ_NO_STOP] = !sy[SY_MOSI];
            ev[IRQ_RX_ERR] = st.urx_perr || !sy[SY_MOSI];
            if (sy[SY_MOSI] && !st.urx_perr) begin
              next_st.det = DET_UART;
            end
          end
        end
        default: next_st.urx = U_IDLE;
      endcase
    end

    // uart command length reached one cycle after the byte
    if (st.len_chk && st.ucnt == cmd_len) begin
      next_st.cmd_done = 1'b1;
      next_st.ucnt = 8'h00;
      next_st.txn = 1'b0;
      next_st.hold = 2'h2;
    end

    // uart transmitter, gated by clear-to-send
    if (st.det == DET_UART) begin
      unique case (st.utx)
        U_IDLE: begin
          next_st.miso_out = 1'b1;
          if (st.pend && (!st.cfg.cts_en || !sy[SY_NSS])) begin
            next_st.utx = U_START;
            next_st.miso_out = 1'b0;
            next_st.utx_div = div;
            next_st.utx_sh = st.pend_d;
            next_st.pend = 1'b0;
          end
        end
        U_START: begin
          if (st.utx_div != 16'h0000) begin
            next_st.utx_div = st.utx_div - 16'h0001;
          end else begin
            next_st.utx = U_DATA;
            next_st.miso_out = st.utx_sh[0];
            next_st.utx_bit = 3'h0;
            next_st.utx_div = div;
          end
        end
        U_DATA: begin
          if (st.utx_div != 16'h0000) begin
            next_st.utx_div = st.utx_div - 16'h0001;
          end else begin
            next_st.utx_div = div;
            if (st.utx_bit == 3'h7) begin
              next_st.utx = (st.cfg.parity == PAR_NONE) ? U_STOP : U_PAR;
              next_st.miso_out = (st.cfg.parity == PAR_NONE) ? 1'b1 :
                                 (^st.utx_sh ^ (st.cfg.parity == PAR_ODD));
              next_st.utx_stop2 = st.cfg.two_stop;
            end else begin
              next_st.utx_sh = {st.utx_sh[0], st.utx_sh[7:1]}; // rotate keeps parity of the frame byte
              next_st.miso_out = st.utx_sh[1];
              next_st.utx_bit = st.utx_bit + 3'h1;
            end
          end
        end
        U_PAR: begin
          if (st.utx_div != 16'h0000) begin
            next_st.utx_div = st.utx_div - 16'h0001;
          end else begin
            next_st.utx = U_STOP;
            next_st.miso_out = 1'b1;
            next_st.utx_div = div;
          end
        end
        U_STOP: begin
          if (st.utx_div != 16'h0000) begin
            next_st.utx_div = st.utx_div - 16'h0001;
          end else if (st.utx_stop2) begin
            next_st.utx_stop2 = 1'b0;
            next_st.utx_div = div;
          end else begin
            next_st.utx = U_IDLE;
            ev[IRQ_TX_EMPTY] = 1'b1;
          end
        end
        default: next_st.utx = U_IDLE;
      endcase
      next_st.miso_oe = 1'b1;
    end

    // shared clock / request-to-send pin
    unique case (next_st.det)
      DET_BOTH: begin
        next_st.sck_oe = 1'b0;
        next_st.sck_pull = 1'b1;
        next_st.sck_out = 1'b0;
      end
      DET_SPI: begin
        next_st.sck_oe = 1'b0;
        next_st.sck_pull = 1'b0;
        next_st.sck_out = 1'b0;
      end
      DET_UART: begin
        next_st.sck_oe = 1'b1;
        next_st.sck_pull = 1'b0;
        next_st.sck_out = core_busy;
      end
      default: next_st.det = DET_BOTH;
    endcase

    // external interrupt from pins set as inputs
    ev[IRQ_EXT_PIN] = |(st.map.is_input & sy[SY_PIN+:NPINS] & ~st.prev[SY_PIN+:NPINS]);
    ev[IRQ_CORE+:CORE_IRQ_W] = core_irq;

    // sticky cause bits, a new event beats the clear
    next_st.cause = (st.cause & ~(clr_load ? clr_mask : '0)) | ev;
    for (int i = 0; i < NPINS; i++) begin
      next_st.pin_out[i] = |(next_st.cause & st.map.mask[i]);
    end

    // busy covers start-up, sleep, transactions and processing
    next_st.busy = !standby_reached || sleep_mode || next_st.txn || core_busy ||
                   (next_st.hold != 2'h0);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.det <= DET_BOTH;
      st.prev <= SY_RST;
      st.urx <= U_IDLE;
      st.utx <= U_IDLE;
      st.cfg <= '{baud: BAUD_RST, parity: PAR_RST, two_stop: STOP2_RST, cts_en: CTS_EN_RST};
      st.busy <= 1'b1;
      st.sck_pull <= 1'b1;
      st.miso_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign sck_out = st.sck_out;
  assign sck_oe = st.sck_oe;
  assign sck_pull_low = st.sck_pull;
  assign miso_out = st.miso_out;
  assign miso_oe = st.miso_oe;
  assign busy = st.busy;
  assign mp_pin_out = st.pin_out;
  assign mp_pin_oe = ~st.map.is_input;
  assign tx_ready = !st.pend;
  assign rx = st.rx;
  assign cmd_done = st.cmd_done;
  assign wake_req = st.wake;
  assign irq_cause = st.cause;
  assign det_mode = st.det;
endmodule

// *** tb/dsp_port_assertions.sv ***
`timescale 1ns/10ps
module dsp_port_assertions #(
  parameter int unsigned CLK_HZ = dsp_pkg::CLK_HZ_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_nss_in,
  input wire logic sck_oe,
  input wire logic sck_pull_low,
  input wire logic miso_oe,
  input wire logic busy,
  input wire logic sleep_mode,
  input wire logic standby_reached,
  input wire dsp_pkg::dsp_rx_t rx,
  input wire logic clr_load,
  input wire logic [dsp_pkg::CORE_IRQ_W-1:0] core_irq,
  input wire logic [dsp_pkg::IRQ_W-1:0] irq_cause,
  input wire dsp_pkg::dsp_det_t det_mode
);
  import dsp_pkg::*;
  // ----------
  // port checks
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_det_onehot: assert property ($onehot(det_mode))
    else $error("mode not one-hot");
  a_det_sticky: assert property (det_mode != DET_BOTH |=> $stable(det_mode))
    else $error("mode left its lock");
  a_rx_mode: assert property (rx.valid |-> det_mode != (rx.from_uart ? DET_SPI : DET_UART))
    else $error("byte from locked-out side");
  a_pull_idle: assert property (det_mode == DET_BOTH |-> sck_pull_low && !sck_oe)
    else $error("clock pin not weakly low");
  a_uart_pins: assert property ($past(det_mode) == DET_UART && det_mode == DET_UART |->
    sck_oe && !sck_pull_low && miso_oe) else $error("uart pins not driven");
  a_miso_float: assert property ((spi_nss_in && det_mode != DET_UART)[*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_busy_sleep: assert property (sleep_mode || !standby_reached |=> busy)
    else $error("busy low before standby");
  a_busy_xfer: assert property ((!spi_nss_in && det_mode != DET_UART)[*6] |-> busy)
    else $error("busy low during transfer");
  a_cause_hold: assert property (!clr_load |=> (irq_cause & $past(irq_cause)) == $past(irq_cause))
    else $error("cause dropped without clear");
  a_core_event: assert property (core_irq[0] |-> ##[1:2] irq_cause[IRQ_CORE])
    else $error("core event lost");
  c_spi: cover property (det_mode == DET_SPI);
  c_uart: cover property (det_mode == DET_UART);
  c_urx: cover property (rx.valid && rx.from_uart);
endmodule
bind dsp_port dsp_port_assertions #(.CLK_HZ(CLK_HZ)) chk_u (.clock, .rst_n, .spi_nss_in, .sck_oe,
  .sck_pull_low, .miso_oe, .busy, .sleep_mode, .standby_reached, .rx, .clr_load, .core_irq, .irq_cause,
  .det_mode);

// *** tb/dsp_host_model.sv ***
`timescale 1ns/10ps
module dsp_host_model #(
  parameter int BT = 100
) (
  input wire logic clock,
  input wire logic miso,
  output logic nss,
  output logic sck,
  output logic mosi
);
  // ----------
  // host side of the shared pins
  // ----------
  initial begin
    nss = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
  end
  // step to just after a clock edge
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // select, released mosi shows inverse of last bit
  task automatic sel(input logic v);
    tk(10);
    nss = v;
    if (v) mosi = ~mosi;
    tk(10);
  endtask
  // n bits msb first, 80 ns clock, miso taken at the rise
  task automatic bits(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi = d[i];
      tk(10);
      sck = 1'b1;
      q[i] = miso;
      tk(10);
      sck = 1'b0;
    end
  endtask
  // one uart frame, bad flips the parity
  task automatic uart(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    mosi = 1'b1;
    tk(3 * BT);
    for (int i = 0; i < 11; i++) begin
      mosi = f[i];
      tk(BT);
    end
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  import dsp_pkg::*;
  localparam int unsigned CHZ = 11_520_000;
  localparam int BT = CHZ / BAUD_115K2;
  localparam logic [7:0] ST = 8'h5A;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic nss, h_sck, sck_w, mosi, miso_w, miso_last = 1'b1;
  logic sck_out, sck_oe, sck_pull_low, miso_out, miso_oe, busy, tx_ready, cmd_done, wake_req;
  logic [2:0] mp_pin_in = 3'h0;
  logic [2:0] mp_pin_out, mp_pin_oe;
  logic sleep_mode = 1'b1;
  logic core_busy = 1'b0, ucfg_load = 1'b0;
  logic [7:0] status_byte = ST, cmd_len = 8'h01;
  dsp_ucfg_t ucfg_in = '0;
  logic standby_reached = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_load = 1'b0;
  dsp_rx_t rx;
  dsp_map_t map_in = '0;
  logic map_load = 1'b0;
  logic [7:0] clr_mask = 8'h00;
  logic clr_load = 1'b0;
  logic [1:0] core_irq = 2'h0;
  logic [7:0] irq_cause, q, rx_last;
  dsp_det_t det_mode;
  logic [10:0] fr;
  logic [15:0] rows [3] = '{16'hA55A, 16'h3CC3, 16'h817E};
  int ev [5] = '{default: 0};
  int err_total = 0;
  int checked = 0;
  int b, c, s;
  // ----------
  // clock, pins, design
  // ----------
  always #2 clock = ~clock;
  assign sck_w = sck_oe ? sck_out : h_sck;
  assign miso_w = miso_oe ? miso_out : ~miso_last;
  dsp_host_model #(.BT(BT)) host_u (.clock, .miso(miso_w), .nss, .sck(h_sck), .mosi);
  dsp_port #(.CLK_HZ(CHZ)) dut_u (.clock, .rst_n, .spi_nss_in(nss), .sck_in(sck_w), .sck_out, .sck_oe,
    .sck_pull_low, .mosi_in(mosi), .miso_out, .miso_oe, .busy, .mp_pin_in, .mp_pin_out, .mp_pin_oe,
    .sleep_mode, .standby_reached, .core_busy, .status_byte, .tx_data, .tx_load, .tx_ready,
    .rx, .cmd_len, .cmd_done, .wake_req, .ucfg_in, .ucfg_load, .map_in, .map_load,
    .clr_mask, .clr_load, .core_irq, .irq_cause, .det_mode);
  // event counters and last byte
  always @(posedge clock) begin
    if (miso_oe) miso_last <= miso_out;
    if (rx.valid === 1'b1) rx_last <= rx.data;
    if (rx.valid === 1'b1) ev[0] <= ev[0] + 1;
    if (cmd_done === 1'b1) ev[1] <= ev[1] + 1;
    if (wake_req === 1'b1) ev[2] <= ev[2] + 1;
    if (busy === 1'b0) ev[3] <= ev[3] + 1;
    if (miso_out === 1'b0 && det_mode === DET_UART) ev[4] <= ev[4] + 1;
  end
  task automatic close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] sv, input logic [31:0] e);
    checked++;
    if (sv !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, sv, e);
    end
  endtask
  task automatic wt(input int k, input int v);
    for (int i = 0; i < 4000; i++) begin
      if (ev[k] >= v) return;
      host_u.tk(1);
    end
    err_total++;
    close_out;
  endtask
  task automatic rs();
    rst_n = 1'b0;
    host_u.tk(6);
    rst_n = 1'b1;
    host_u.tk(1);
  endtask
  task automatic ld(input logic [7:0] d);
    tx_data = d;
    tx_load = 1'b1;
    host_u.tk(1);
    tx_load = 1'b0;
  endtask
  // n copies of d in one select, waits for completion
  task automatic xfer(input logic [7:0] d, input int n);
    wt(3, ev[3] + 1);
    b = ev[0];
    c = ev[1];
    host_u.sel(1'b0);
    repeat (n) host_u.bits(d, 8, q);
    host_u.sel(1'b1);
    wt(1, c + 1);
    chk(ev[0], b + n);
  endtask
  // ----------
  // scenarios
  // ----------
  initial begin
    rs();
    chk(busy, 1'b1);
    chk(det_mode, DET_BOTH);
    chk({sck_pull_low, sck_oe, miso_oe, tx_ready}, 4'h9);
    chk(irq_cause, 8'h00);
    host_u.sel(1'b0);
    host_u.sel(1'b1);
    wt(2, 1);
    sleep_mode = 1'b0;
    host_u.tk(20);
    chk(busy, 1'b1);
    standby_reached = 1'b1;
    wt(3, 1);
    foreach (rows[r]) begin
      if (rows[r][7:0] != ST) ld(rows[r][7:0]);
      xfer(rows[r][15:8], 1);
      chk(q, rows[r][7:0]);
      chk(rx_last, rows[r][15:8]);
      chk(det_mode, DET_SPI);
      chk(miso_oe, 1'b0);
    end
    xfer(8'h34, 2);
    chk(q, ST);
    host_u.tk(20);
    chk(ev[1], c + 1);
    host_u.sel(1'b0);
    host_u.bits(8'hF0, 4, q);
    host_u.sel(1'b1);
    host_u.tk(20);
    chk(ev[1], c + 1);
    chk(ev[0], b + 2);
    host_u.uart(8'h55, 1'b0);
    chk(ev[0], b + 2);
    core_irq = 2'h1;
    host_u.tk(1);
    core_irq = 2'h0;
    map_in.is_input = 3'h4;
    map_in.mask[0] = 8'h40;
    map_load = 1'b1;
    host_u.tk(1);
    map_load = 1'b0;
    host_u.tk(3);
    chk({mp_pin_oe, mp_pin_out}, 6'h19);
    mp_pin_in = 3'h4;
    host_u.tk(6);
    chk(irq_cause[IRQ_EXT_PIN], 1'b1);
    clr_mask = 8'hFF;
    clr_load = 1'b1;
    host_u.tk(1);
    clr_load = 1'b0;
    host_u.tk(3);
    chk({irq_cause, mp_pin_out}, 11'h000);
    rs();
    b = ev[0];
    c = ev[1];
    host_u.uart(8'h96, 1'b0);
    chk(rx_last, 8'h96);
    chk(det_mode, DET_UART);
    chk({sck_oe, sck_pull_low, miso_oe}, 3'h5);
    wt(1, c + 1);
    core_busy = 1'b1;
    host_u.tk(2);
    chk({sck_out, busy}, 2'h3);
    core_busy = 1'b0;
    host_u.uart(8'h96, 1'b1);
    chk(irq_cause[IRQ_PARITY:IRQ_RX_FULL], 4'hD);
    ld(8'h2D);
    host_u.tk(3 * BT);
    chk(miso_out, 1'b1);
    s = ev[4];
    host_u.sel(1'b0);
    wt(4, s + 1);
    fr = {1'b1, ^8'h2D, 8'h2D, 1'b0};
    host_u.tk(BT / 2);
    for (int i = 0; i < 11; i++) begin
      chk(miso_out, fr[i]);
      host_u.tk(BT);
    end
    chk(irq_cause[IRQ_TX_EMPTY], 1'b1);
    // odd parity, two-byte command: flipped frame is now clean, no completion yet
    cmd_len = 8'h02;
    ucfg_in = '{baud: BSEL_115K2, parity: PAR_ODD, two_stop: 1'b0, cts_en: 1'b0};
    ucfg_load = 1'b1;
    clr_load = 1'b1;
    host_u.tk(1);
    {ucfg_load, clr_load} = 2'b00;
    c = ev[1];
    host_u.uart(8'h96, 1'b1);
    chk({irq_cause[IRQ_PARITY], irq_cause[IRQ_RX_FULL], ev[1] == c}, 3'h3);
    b = ev[0];
    host_u.bits(8'hFF, 8, q);
    host_u.tk(20);
    chk({ev[0] == b, det_mode}, {1'b1, DET_UART});
    close_out;
  end
endmodule
